// ---- verif/lpm_ctrl_monitor.sv ----
// Checker of the power-mode outputs of the mode controller
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl_monitor (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        RD_STB,
  input wire logic [31:0] RDATA,
  input wire logic        CORE_PWR_OK,
  input wire logic        XFER_BUSY,
  input wire logic        CPU_CLK_EN,
  input wire logic        PLL_EN,
  input wire logic        XTAL_EN,
  input wire logic        USB_XCVR_EN,
  input wire logic        SS_PHY_EN,
  input wire logic        SS_PHY_U3,
  input wire logic        RAM_RETAIN,
  input wire logic        BUF_RETAIN,
  input wire logic        IO_HOLD,
  input wire logic        CPU_PC_RST
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // Restart pulse stays quiet over the first 8 cycles of the exit settle
  sequence no_pc_rst;
    !CPU_PC_RST [*8];
  endsequence
  // Core supply gone for more than a glitch
  sequence supply_lost;
    !CORE_PWR_OK [*2];
  endsequence
  chk_u3_clk_off: assert property (SS_PHY_U3 |-> !CPU_CLK_EN && SS_PHY_EN)
    else $error("parked phy with cpu clock running");
  chk_susp_retain: assert property (SS_PHY_U3 |-> RAM_RETAIN && BUF_RETAIN && IO_HOLD)
    else $error("suspend state without retention");
  chk_cpu_needs_pll: assert property (CPU_CLK_EN |-> PLL_EN && XTAL_EN)
    else $error("cpu clock without pll or oscillator");
  chk_xtal_off_all: assert property (!XTAL_EN |-> !PLL_EN && !USB_XCVR_EN && !CPU_CLK_EN)
    else $error("oscillator off while a consumer runs");
  chk_busy_holds: assert property (XFER_BUSY && CPU_CLK_EN |=> CPU_CLK_EN)
    else $error("entry while transfers pending");
  chk_supply_loss: assert property (supply_lost |-> ##[0:20] (!RAM_RETAIN && !BUF_RETAIN))
    else $error("state kept after supply loss");
  chk_susp_keeps_pc: assert property ($fell(SS_PHY_U3) |-> no_pc_rst)
    else $error("program counter reset on suspend wake");
  chk_standby_restart: assert property ($rose(XTAL_EN) |-> ##[0:30] CPU_PC_RST)
    else $error("no core restart after standby");
  chk_rdata_quiet: assert property (!$past(RD_STB) |-> RDATA == 32'h0000_0000)
    else $error("read data outside the answer cycle");
endmodule // lpm_ctrl_monitor
bind lpm_ctrl lpm_ctrl_monitor u_mon (.REF_CLK(REF_CLK), .RST_B(RST_B), .RD_STB(RD_STB),
  .RDATA(RDATA), .CORE_PWR_OK(CORE_PWR_OK), .XFER_BUSY(XFER_BUSY), .CPU_CLK_EN(CPU_CLK_EN),
  .PLL_EN(PLL_EN), .XTAL_EN(XTAL_EN), .USB_XCVR_EN(USB_XCVR_EN), .SS_PHY_EN(SS_PHY_EN),
  .SS_PHY_U3(SS_PHY_U3), .RAM_RETAIN(RAM_RETAIN), .BUF_RETAIN(BUF_RETAIN),
  .IO_HOLD(IO_HOLD), .CPU_PC_RST(CPU_PC_RST));
`default_nettype wire

// ---- verif/lpm_host.sv ----
// Host processor model: master of the register port, mailbox requests included
`timescale 1ns/100ps
`default_nettype none
module lpm_host (
  input  wire logic        clk,
  input  wire logic [31:0] rdata,
  output var  logic [7:0]  addr,
  output var  logic [31:0] wdata,
  output var  logic        wr_stb,
  output var  logic        rd_stb
);
  // Bus idle from time zero
  initial begin
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // One-cycle write; released data are inverted so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    wdata <= ~d;
  endtask
  // Data taken in the cycle after the strobe only; host reads before standby
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // lpm_host
`default_nettype wire

// ---- verif/test_lpm_ctrl.sv ----
// Self-checking bench of the power-mode controller
`timescale 1ns/100ps
`default_nettype none
module test_lpm_ctrl;
  logic clk = 1'b0, rst_b = 1'b0, dp = 1'b0, role = 1'b0, ssr = 1'b0, vbus = 1'b0;
  logic par0 = 1'b0, cts = 1'b0, pwr_ok = 1'b1, busy = 1'b0, c32 = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic wr_stb, rd_stb, cpu_clk, pll, xtal, xcvr, phy, u3, ram, hold, pc_rst, reload, irq;
  logic [15:0] pu, pd, gsel;
  int num_errors = 0, checked = 0, pc_seen;
  lpm_host u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb));
  lpm_ctrl DUT (.REF_CLK(clk), .RST_B(rst_b), .CLK_EN(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .DP_IN(dp), .DM_IN(1'b0),
    .ROLE_ID_CHG(role), .SS_RX_RESUME(ssr), .VBUS_DET(vbus), .UART_CTS(cts),
    .PAR_CTRL0(par0), .CORE_PWR_OK(pwr_ok), .XFER_BUSY(busy), .CLK32_INT(c32),
    .CLK32_EXT(c32), .CPU_CLK_EN(cpu_clk), .PLL_EN(pll), .XTAL_EN(xtal),
    .USB_XCVR_EN(xcvr), .SS_PHY_EN(phy), .SS_PHY_U3(u3), .CORE_PWR_EN(), .RAM_RETAIN(ram),
    .BUF_RETAIN(), .IO_HOLD(hold), .CPU_PC_RST(pc_rst), .FW_RELOAD_REQ(reload),
    .WDT_IRQ(irq), .PIN_PULLUP_EN(pu), .PIN_PULLDN_EN(pd), .PIN_GPIO_SEL(gsel));
  // 10 MHz clock
  initial forever #50 clk = ~clk;
  // Fast stand-in for the slow watchdog clock keeps the run short
  initial forever begin
    repeat (3) @(posedge clk);
    c32 <= ~c32;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run;
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Bounded wait for the cpu clock to reach a level, noting restart pulses
  task automatic wait_cpu(input logic lvl);
    int n;
    int lim;
    n = 0;
    lim = 0;
    pc_seen = 0;
    // Stay past the exit settle so a restart pulse in NORMAL is seen
    while (cpu_clk !== lvl || n < 15) begin
      @(posedge clk);
      #1 if (pc_rst === 1'b1) pc_seen = 1;
      if (cpu_clk !== lvl) n = 0; else n++;
      lim++;
      if (lim > 2000) begin
        num_errors++;
        complete_run();
      end
    end
  endtask
  // Request a mode through control or mailbox, then let the entry settle
  task automatic go(input logic [2:0] m, input bit mbx);
    u_host.wr(mbx ? 8'h1C : 8'h00, {29'h0, m});
    wait_cpu(1'b0);
    repeat (15) @(posedge clk);
  endtask
  // One-cycle pulse on a wake source; source 0 toggles the USB D+ line instead
  task automatic kick(input int s);
    case (s)
      0: dp <= ~dp;
      1: role <= 1'b1;
      2: ssr <= 1'b1;
      3: vbus <= 1'b1;
      4: par0 <= 1'b1;
      default: cts <= 1'b1;
    endcase
    @(posedge clk);
    {role, ssr, vbus, par0, cts} <= 5'h00;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    chk("cpu clock", cpu_clk, 1);
    u_host.rd(8'h10, d);
    chk("wdt load", d, 32'h0000_8000);
    u_host.rd(8'h40, d);
    chk("unmapped", d, 32'h0);
    u_host.wr(8'h18, 32'h0000_0009);
    u_host.wr(8'h20, 32'h0000_00A5);
    u_host.wr(8'h04, 32'h0000_0001);
    chk("reload at reset", reload, 1);
    u_host.wr(8'h08, 32'h0000_0002);
    u_host.rd(8'h18, d);
    chk("reload ack", reload, 0);
    chk("pin cfg", d, 32'h0000_0009);
    chk("pull up", pu, 16'h0001);
    chk("pull down", pd, 16'h0002);
    chk("gpio sel", gsel, 16'h00A5);
    for (int i = 0; i < 6; i++) begin
      go(i[0] ? 3'h2 : 3'h1, i[0]);
      chk("phy u3", u3, {31'h0, !i[0]});
      chk("phy on", phy, {31'h0, !i[0]});
      chk("pll", pll, 0);
      chk("io hold", hold, 1);
      if (i == 0) u_host.wr(8'h1C, 32'h0000_0003);
      kick(i);
      wait_cpu(1'b1);
      chk("pc kept", pc_seen, 0);
    end
    repeat (20) @(posedge clk);
    chk("ignored request", xtal, 1);
    go(3'h3, 1'b1);
    chk("xtal", xtal, 0);
    chk("transceiver", xcvr, 0);
    kick(0);
    repeat (30) @(posedge clk);
    chk("standby usb wake", cpu_clk, 0);
    kick(3);
    wait_cpu(1'b1);
    chk("pc restart", pc_seen, 1);
    busy <= 1'b1;
    u_host.wr(8'h00, 32'h0000_0001);
    repeat (30) @(posedge clk);
    chk("busy blocks", cpu_clk, 1);
    busy <= 1'b0;
    wait_cpu(1'b0);
    repeat (15) @(posedge clk);
    kick(1);
    wait_cpu(1'b1);
    u_host.wr(8'h10, 32'h0000_0020);
    u_host.wr(8'h0C, 32'h0000_0003);
    repeat (600) @(posedge clk);
    chk("wdt irq", irq, 1);
    u_host.wr(8'h0C, 32'h0000_0000);
    u_host.wr(8'h08, 32'h0000_0001);
    repeat (600) @(posedge clk);
    chk("wdt off", irq, 0);
    u_host.wr(8'h0C, 32'h0000_0005);
    go(3'h3, 1'b0);
    wait_cpu(1'b1);
    chk("wdt wake", pc_seen, 1);
    pwr_ok <= 1'b0;
    repeat (30) @(posedge clk);
    chk("ram lost", ram, 0);
    pwr_ok <= 1'b1;
    repeat (40) @(posedge clk);
    chk("reload", reload, 1);
    complete_run();
  end
endmodule // test_lpm_ctrl
`default_nettype wire

// ---- verilog/lpm_ctrl.v ----
// Low-power mode controller with wake logic, watchdog and pin hold control
// Function
// [RULE1] Four low-power modes besides normal
// [RULE2] Normal mode runs processor clock and PLLs
// [RULE3] Suspend entered by firmware or mailbox
// [RULE4] Suspend wakes on USB, VBUS, CTS, ctrl0, reset
// [RULE5] Standby wakes on VBUS, CTS, ctrl0, reset
// [RULE6] Suspend with PHY on: PHY in U3, others stopped
// [RULE7] Suspend with PHY off: PHY off, PLLs off
// [RULE8] Suspend keeps RAM, registers, pins held
// [RULE9] Transfers finish before suspend entry
// [RULE10] Suspend wake keeps program counter
// [RULE11] Standby keeps registers and RAM only; IO_HOLD also holds the pins in standby
// [RULE12] Standby wake resets program counter, restarts core
// [RULE13] Standby stops oscillator, PLL, transceiver, core
// [RULE14] Core power-down loses all, needs reload
// [RULE15] Watchdog interrupts, wakes standby, resets core
// [RULE16] Watchdog counts 32 kHz, optional external
// [RULE17] Firmware may disable the watchdog
// [RULE18] Pins: high-Z, pull-up, pull-down, hold
// [RULE19] Unused interface pins usable as GPIO
// [RULE20] Wake sources synchronised and latched
// [RULE21] Entry requests ignored during transitions
`timescale 1ns/100ps
`default_nettype none
`include "lpm_map.vh"

module lpm_ctrl #(
  parameter WDT_W   = 16,   // Watchdog counter width
  parameter NPINS   = 16    // Number of configurable digital pins
) (
  input  wire              REF_CLK,
  input  wire              RST_B,
  input  wire              CLK_EN,
  input  wire [7:0]        ADDR,
  input  wire [31:0]       WDATA,
  input  wire              WR_STB,
  input  wire              RD_STB,
  output reg  [31:0]       RDATA,
  input  wire              DP_IN,
  input  wire              DM_IN,
  input  wire              ROLE_ID_CHG,
  input  wire              SS_RX_RESUME,
  input  wire              VBUS_DET,
  input  wire              UART_CTS,
  input  wire              PAR_CTRL0,
  input  wire              CORE_PWR_OK,
  input  wire              XFER_BUSY,
  input  wire              CLK32_INT,
  input  wire              CLK32_EXT,
  output wire              CPU_CLK_EN,
  output wire              PLL_EN,
  output wire              XTAL_EN,
  output wire              USB_XCVR_EN,
  output wire              SS_PHY_EN,
  output wire              SS_PHY_U3,
  output wire              CORE_PWR_EN,
  output wire              RAM_RETAIN,
  output wire              BUF_RETAIN,
  output wire              IO_HOLD,
  output wire              CPU_PC_RST,
  output wire              FW_RELOAD_REQ,
  output wire              WDT_IRQ,
  output wire [NPINS-1:0]  PIN_PULLUP_EN,
  output wire [NPINS-1:0]  PIN_PULLDN_EN,
  output wire [NPINS-1:0]  PIN_GPIO_SEL
);

  // One-hot mode states
  localparam [6:0] ST_NORMAL   = 7'h01;  // Full function
  localparam [6:0] ST_ENTER    = 7'h02;  // Settling into a low-power mode
  localparam [6:0] ST_SUSP_ON  = 7'h04;  // Suspend, SuperSpeed PHY in U3
  localparam [6:0] ST_SUSP_OFF = 7'h08;  // Suspend, SuperSpeed PHY off
  localparam [6:0] ST_STANDBY  = 7'h10;  // Standby
  localparam [6:0] ST_EXIT     = 7'h20;  // Clocks restarting after wake
  localparam [6:0] ST_PWR_DOWN = 7'h40;  // Core supply removed
  localparam integer SETTLE_INT = `LPM_SETTLE_CYC;  // Settle length in whole cycles
  localparam [3:0] SETTLE_CYC  = SETTLE_INT[3:0];  // Cut to the counter width on purpose

  // Mode flow in short:
  //   NORMAL -> ENTER -> SUSP_ON, SUSP_OFF or STANDBY -> EXIT -> NORMAL
  //   any settled mode -> PWR_DOWN when core supply goes, back to NORMAL when it returns
  // ENTER and EXIT both run a fixed settle count so that clocks and
  // supplies have time to stop or start before the next mode shows.
  // The count is short on purpose: a longer settle only costs latency
  // on wake, and the wake latches below keep events that arrive meanwhile.
  // Requests are only taken in NORMAL; anything written in another mode
  // is dropped rather than queued, so software must poll the status word.
  // Supply loss during ENTER or EXIT is acted on once the mode settles,
  // which keeps the transition counters simple at the cost of a few cycles.

  reg  [6:0]        state_ff;        // Current mode state
  reg  [6:0]        nxt_state;
  reg  [2:0]        target_ff;       // Mode being entered
  reg  [2:0]        nxt_target;
  reg  [3:0]        settle_ff;       // Transition settle counter
  reg  [3:0]        nxt_settle;
  reg               pc_rst_ff;       // Wake restarts execution
  reg               nxt_pc_rst;
  reg               reload_ff;       // Firmware reload needed
  reg               nxt_reload;
  reg  [2:0]        fw_req_ff;       // Firmware mode request
  reg  [2:0]        mbox_req_ff;     // External processor mailbox request
  reg               cts_pol_ff;      // CTS wake polarity
  reg  [4:0]        wdt_ctrl_ff;     // Watchdog control bits
  reg  [WDT_W-1:0]  wdt_load_ff;     // Watchdog reload value
  reg  [WDT_W-1:0]  wdt_cnt_ff;      // Watchdog down counter
  reg               wdt_irq_ff;      // Sticky watchdog interrupt
  reg  [31:0]       pin_cfg_ff;      // Two bits per pin: pull mode
  reg  [NPINS-1:0]  gpio_sel_ff;     // Pin used as GPIO
  reg  [NPINS-1:0]  pin_hold_ff;     // Pull state for hold; never loaded or read
  reg  [5:0]        sync1_ff;        // First synchroniser stage
  reg  [5:0]        sync2_ff;        // Second synchroniser stage
  reg  [5:0]        prev_ff;         // Last level for change detect
  reg  [5:0]        wake_lat_ff;     // Latched wake events
  reg  [2:0]        c32_sync_ff;     // 32 kHz clock sync and edge
  reg               wdt_wake_ff;     // Watchdog wake pending

  wire [5:0] raw_wake = {PAR_CTRL0, UART_CTS ^ ~cts_pol_ff, VBUS_DET,
                         SS_RX_RESUME, ROLE_ID_CHG, DP_IN ^ DM_IN};
  wire       low_power   = state_ff[2] | state_ff[3] | state_ff[4];
  wire       wr_hit      = CLK_EN & WR_STB;
  wire       c32_rise    = c32_sync_ff[1] & ~c32_sync_ff[2];
  wire       wdt_on      = wdt_ctrl_ff[`LPM_WDT_EN];
  wire       wdt_expire  = wdt_on & c32_rise & (wdt_cnt_ff == {WDT_W{1'b0}});

  // Decode one two-bit pull field
  function [1:0] pull_of;
    input [31:0] cfg;
    input integer idx;
    begin
      pull_of = cfg[2*idx +: 2];
    end
  endfunction

  // Wake events allowed in suspend and standby
  wire sus_wake = |wake_lat_ff;                                  // RULE4
  wire stb_wake = |wake_lat_ff[5:3] | wdt_wake_ff;               // RULE5

  // Wake source synchronisers and latches; latch keeps short pulses
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_ff    <= 6'h00;
      sync2_ff    <= 6'h00;
      prev_ff     <= 6'h00;
      wake_lat_ff <= 6'h00;
      c32_sync_ff <= 3'h0;
    end else if (CLK_EN) begin
      sync1_ff    <= raw_wake;                                   // RULE20
      sync2_ff    <= sync1_ff;
      prev_ff     <= sync2_ff;
      c32_sync_ff <= {c32_sync_ff[1:0],
                      wdt_ctrl_ff[`LPM_WDT_EXT_CLK] ? CLK32_EXT : CLK32_INT}; // RULE16
      if (state_ff[0])
        wake_lat_ff <= 6'h00;                                    // Clear on return to normal
      else begin
        // USB line change is an edge; role pin, SS resume and the others are levels
        wake_lat_ff <= wake_lat_ff |
          {sync2_ff[5:3], sync2_ff[2:1], sync2_ff[0] ^ prev_ff[0]}; // RULE20
      end
    end
  end

  // Mode state machine
  // The restart pulse is a single cycle; the core sees it on its first
  // cycle in NORMAL, after the whole EXIT settle, and starts from the reset vector.
  // A suspend wake leaves it low so execution carries on in place.
  always @* begin
    nxt_state  = state_ff;
    nxt_target = target_ff;
    nxt_settle = settle_ff;
    nxt_pc_rst = 1'b0;
    // Firmware acknowledges its reload by writing one to the status bit
    nxt_reload = reload_ff & ~(wr_hit && ADDR == `LPM_REG_STATUS && WDATA[1]); // RULE14
    case (state_ff)
      ST_NORMAL: begin
        if (!CORE_PWR_OK) begin
          nxt_state = ST_PWR_DOWN;                               // RULE14
        end else if (!XFER_BUSY && (fw_req_ff != `LPM_REQ_NONE ||
                                    mbox_req_ff != `LPM_REQ_NONE)) begin // RULE3 RULE9
          nxt_target = (fw_req_ff != `LPM_REQ_NONE) ? fw_req_ff : mbox_req_ff;
          nxt_state  = ST_ENTER;
          nxt_settle = SETTLE_CYC;
        end
      end
      ST_ENTER: begin
        // Further requests are not looked at here
        if (settle_ff != 4'h0)
          nxt_settle = settle_ff - 4'h1;                         // RULE21
        else begin
          case (target_ff)
            `LPM_REQ_SUSP_ON:  nxt_state = ST_SUSP_ON;           // RULE1
            `LPM_REQ_SUSP_OFF: nxt_state = ST_SUSP_OFF;          // RULE1
            `LPM_REQ_STANDBY:  nxt_state = ST_STANDBY;           // RULE1
            default:           nxt_state = ST_NORMAL;
          endcase
        end
      end
      ST_SUSP_ON, ST_SUSP_OFF: begin
        if (!CORE_PWR_OK)
          nxt_state = ST_PWR_DOWN;
        else if (sus_wake) begin
          nxt_state  = ST_EXIT;                                  // RULE4
          nxt_settle = SETTLE_CYC;
          nxt_pc_rst = 1'b0;                                     // RULE10
        end
      end
      ST_STANDBY: begin
        if (!CORE_PWR_OK)
          nxt_state = ST_PWR_DOWN;
        else if (stb_wake) begin
          nxt_state  = ST_EXIT;                                  // RULE5 RULE15
          nxt_settle = SETTLE_CYC;
        end
      end
      ST_EXIT: begin
        if (settle_ff != 4'h0)
          nxt_settle = settle_ff - 4'h1;
        else begin
          nxt_state  = ST_NORMAL;
          nxt_pc_rst = (target_ff == `LPM_REQ_STANDBY);          // RULE12
        end
      end
      ST_PWR_DOWN: begin
        nxt_reload = 1'b1;                                       // RULE14
        if (CORE_PWR_OK) begin
          nxt_state  = ST_NORMAL;
          nxt_pc_rst = 1'b1;
        end
      end
      default: nxt_state = ST_NORMAL;
    endcase
  end

  // State registers; hardware reset restarts execution
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff  <= ST_NORMAL;
      target_ff <= `LPM_REQ_NONE;
      settle_ff <= 4'h0;
      pc_rst_ff <= 1'b1;                                         // RULE10
      reload_ff <= 1'b1;
    end else if (CLK_EN) begin
      state_ff  <= nxt_state;
      target_ff <= nxt_target;
      settle_ff <= nxt_settle;
      // A watchdog core reset shares the restart pulse with the wakes
      pc_rst_ff <= nxt_pc_rst | (wdt_expire & wdt_ctrl_ff[`LPM_WDT_RST_EN]); // RULE15
      reload_ff <= nxt_reload;
    end
  end

  // Watchdog: counts 32 kHz edges, reloads on expiry
  // The slow clock is only sampled here, never used as a clock, so the
  // whole block stays in one domain; its edges must be well apart from
  // each other compared with the reference period.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wdt_cnt_ff  <= `LPM_WDT_LOAD_RST;
      wdt_irq_ff  <= 1'b0;
      wdt_wake_ff <= 1'b0;
    end else if (CLK_EN) begin
      if (!wdt_on) begin
        wdt_cnt_ff  <= wdt_load_ff;                              // RULE17
        wdt_wake_ff <= 1'b0;
      end else if (c32_rise) begin
        wdt_cnt_ff <= (wdt_cnt_ff == {WDT_W{1'b0}}) ? wdt_load_ff
                                                    : wdt_cnt_ff - 1'b1; // RULE16
      end
      // Set wins over the software clear
      if (wdt_expire && wdt_ctrl_ff[`LPM_WDT_INT_EN])
        wdt_irq_ff <= 1'b1;                                      // RULE15
      else if (wr_hit && ADDR == `LPM_REG_STATUS && WDATA[0])
        wdt_irq_ff <= 1'b0;
      if (wdt_expire && wdt_ctrl_ff[`LPM_WDT_WAKE_EN] && state_ff[4])
        wdt_wake_ff <= 1'b1;                                     // RULE15
      else if (state_ff[0])
        wdt_wake_ff <= 1'b0;
    end
  end

  // Register writes
  // Mode requests are refused outside NORMAL, which also keeps a second
  // request from landing while a transition runs.
  // Configuration words are writable in any mode; the core is stopped in
  // every low-power mode, so there only the external processor writes them.
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fw_req_ff   <= `LPM_REQ_NONE;
      mbox_req_ff <= `LPM_REQ_NONE;
      cts_pol_ff  <= 1'b0;
      wdt_ctrl_ff <= 5'h00;
      wdt_load_ff <= `LPM_WDT_LOAD_RST;
      pin_cfg_ff  <= `LPM_PIN_CFG_RST;
      gpio_sel_ff <= {NPINS{1'b0}};
    end else if (CLK_EN) begin
      // Requests clear once taken into a transition
      if (state_ff[1]) begin
        fw_req_ff   <= `LPM_REQ_NONE;
        mbox_req_ff <= `LPM_REQ_NONE;
      end else if (wr_hit && ADDR == `LPM_REG_CTRL && state_ff[0])
        fw_req_ff <= WDATA[2:0];                                 // RULE3
      else if (wr_hit && ADDR == `LPM_REG_MAILBOX && state_ff[0])
        mbox_req_ff <= WDATA[2:0];                               // RULE3
      if (wr_hit && ADDR == `LPM_REG_WAKE_CFG)
        cts_pol_ff <= WDATA[`LPM_WCFG_CTS_POL];                  // RULE4
      if (wr_hit && ADDR == `LPM_REG_WDT_CTRL)
        wdt_ctrl_ff <= WDATA[4:0];                               // RULE17
      if (wr_hit && ADDR == `LPM_REG_WDT_LOAD)
        wdt_load_ff <= WDATA[WDT_W-1:0];
      if (wr_hit && ADDR == `LPM_REG_PIN_CFG)
        pin_cfg_ff <= WDATA;                                     // RULE18
      if (wr_hit && ADDR == `LPM_REG_GPIO_SEL)
        gpio_sel_ff <= WDATA[NPINS-1:0];                         // RULE19
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B)
      RDATA <= 32'h0000_0000;
    else if (CLK_EN) begin
      RDATA <= 32'h0000_0000;
      if (RD_STB) begin
        case (ADDR)
          `LPM_REG_CTRL:     RDATA <= {29'h0, fw_req_ff};
          `LPM_REG_WAKE_CFG: RDATA <= {31'h0, cts_pol_ff};
          `LPM_REG_STATUS:   RDATA <= {17'h0, wake_lat_ff, state_ff, reload_ff, wdt_irq_ff};
          `LPM_REG_WDT_CTRL: RDATA <= {27'h0, wdt_ctrl_ff};
          `LPM_REG_WDT_LOAD: RDATA <= {{(32-WDT_W){1'b0}}, wdt_load_ff};
          `LPM_REG_WDT_CNT:  RDATA <= {{(32-WDT_W){1'b0}}, wdt_cnt_ff};
          `LPM_REG_PIN_CFG:  RDATA <= pin_cfg_ff;
          `LPM_REG_MAILBOX:  RDATA <= {29'h0, mbox_req_ff};
          `LPM_REG_GPIO_SEL: RDATA <= {{(32-NPINS){1'b0}}, gpio_sel_ff};
          default:           RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin pull controls, decoded straight from the pin configuration word
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
      wire [1:0] pm = pull_of(pin_cfg_ff, gi);
      assign PIN_PULLUP_EN[gi] = pm == 2'h1;                     // RULE18
      assign PIN_PULLDN_EN[gi] = pm == 2'h2;                     // RULE18
      assign PIN_GPIO_SEL[gi]  = gpio_sel_ff[gi];                // RULE19
    end
  endgenerate

  // Clock, power and retention controls per mode
  // All of these decode the registered state or come straight from a flop, so they never glitch.
  // The CPU clock runs through ENTER and EXIT so the core can finish its
  // own hand-over and pick up the restart pulse.
  // Buffer retention is only claimed in suspend; standby may lose buffers.
  assign CPU_CLK_EN    = state_ff[0] | state_ff[1] | state_ff[5]; // RULE2 RULE6
  assign PLL_EN        = ~(low_power | state_ff[6]);             // RULE2 RULE7
  assign XTAL_EN       = ~(state_ff[4] | state_ff[6]);           // RULE13
  assign USB_XCVR_EN   = ~(state_ff[4] | state_ff[6]);           // RULE13
  assign SS_PHY_EN     = ~(state_ff[3] | state_ff[4] | state_ff[6]); // RULE7
  assign SS_PHY_U3     = state_ff[2];                            // RULE6
  assign CORE_PWR_EN   = ~(state_ff[4] | state_ff[6]);           // RULE13
  assign RAM_RETAIN    = ~state_ff[6];                           // RULE8 RULE11
  assign BUF_RETAIN    = state_ff[2] | state_ff[3];              // RULE8 RULE11
  assign IO_HOLD       = low_power;                              // RULE8 RULE18
  assign CPU_PC_RST    = pc_rst_ff;                              // RULE12
  assign FW_RELOAD_REQ = reload_ff;                              // RULE14
  assign WDT_IRQ       = wdt_irq_ff;                             // RULE15

endmodule // lpm_ctrl
`default_nettype wire

// ---- verilog/lpm_map.vh ----
// Register offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef LPM_MAP_VH
`define LPM_MAP_VH

// Register offsets (byte addresses, one 32-bit word each)
`define LPM_REG_CTRL      8'h00
`define LPM_REG_WAKE_CFG  8'h04
`define LPM_REG_STATUS    8'h08
`define LPM_REG_WDT_CTRL  8'h0C
`define LPM_REG_WDT_LOAD  8'h10
`define LPM_REG_WDT_CNT   8'h14
`define LPM_REG_PIN_CFG   8'h18
`define LPM_REG_MAILBOX   8'h1C
`define LPM_REG_GPIO_SEL  8'h20

// Mode request codes (CTRL[2:0] and MAILBOX[2:0])
`define LPM_REQ_NONE      3'h0
`define LPM_REQ_SUSP_ON   3'h1
`define LPM_REQ_SUSP_OFF  3'h2
`define LPM_REQ_STANDBY   3'h3

// Wake configuration bits
`define LPM_WCFG_CTS_POL  0

// Watchdog control bits
`define LPM_WDT_EN        0
`define LPM_WDT_INT_EN    1
`define LPM_WDT_WAKE_EN   2
`define LPM_WDT_RST_EN    3
`define LPM_WDT_EXT_CLK   4

// Reset values
`define LPM_WDT_LOAD_RST  16'h8000
`define LPM_PIN_CFG_RST   32'h0000_0000

// Transition timing: 1000 ns settle at 100 ns clock period
`define LPM_SETTLE_NS     1000
`define LPM_CLK_NS        100
`define LPM_SETTLE_CYC    ((`LPM_SETTLE_NS + `LPM_CLK_NS - 1) / `LPM_CLK_NS)

`endif
